// *** src/hcs_flag_cell.sv ***
`timescale 1ns/10ps
module hcs_flag_cell (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_clk_en,
   input  wire logic i_set,
   input  wire logic i_clear,
   output logic      o_flag
);
   import hcs_pkg::*;

   logic flag_reg;

   // set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_reg <= 1'b0;
      end else if (i_clk_en) begin
         if (i_set) begin
            flag_reg <= 1'b1;
         end else if (i_clear) begin
            flag_reg <= 1'b0;
         end
      end
   end

   assign o_flag = flag_reg;

endmodule : hcs_flag_cell

// *** src/hcs_pkg.sv ***
package hcs_pkg;

   // ***********************************************
   // status register layout
   // ***********************************************
   localparam int unsigned HCS_STATUS_W     = 8;
   localparam int unsigned HCS_BIT_USER7    = 7;
   localparam int unsigned HCS_BIT_USER6    = 6;
   localparam int unsigned HCS_BIT_USER5    = 5;
   localparam int unsigned HCS_BIT_USER4    = 4;
   localparam int unsigned HCS_BIT_CMD      = 3;
   localparam int unsigned HCS_BIT_USER2    = 2;
   localparam int unsigned HCS_BIT_IN_FULL  = 1;
   localparam int unsigned HCS_BIT_OUT_FULL = 0;

   localparam logic [7:0] HCS_USER_MASK    = 8'hF4;
   localparam logic [7:0] HCS_STATUS_RESET = 8'h00;
   localparam logic       HCS_CMD_IS_DATA  = 1'b0;
   localparam logic       HCS_CMD_IS_CMD   = 1'b1;

   // ***********************************************
   // event carriers
   // ***********************************************
   typedef struct packed {
      logic wr_input;
      logic addr_bit2;
      logic rd_output;
      logic rd_status;
   } hcs_host_ev_type;

   typedef struct packed {
      logic       wr_status;
      logic [7:0] wr_data;
      logic       rd_input;
      logic       wr_output;
   } hcs_local_ev_type;

   typedef struct packed {
      logic on;
      logic set;
      logic clear;
   } hcs_fast_gate_type;

endpackage : hcs_pkg

// *** src/hcs_status.sv ***
`timescale 1ns/10ps
// Operation
// - Bits 7, 6, 5, 4 and 2 are user bits written by the local processor, read-only to host.
// - Each host write of the input data register copies address bit 2 into status bit 3.
// - Status bit 3 at 0 marks data in the input register and at 1 marks a command.
// - The input-full flag at bit 1 is read-only and drives the local interrupt request.
// - A host I/O write of the input data register sets the input-full flag.
// - A local read of the input data register clears the input-full flag.
// - With fast gate-A20 in use, alternate set and clear terms steer the input-full flag.
// - A local write of the output data register sets the output-full flag at bit 0.
// - A host I/O read of the output data register clears the output-full flag.
// - A local write of 0 to bit 0 clears the output-full flag; the host only reads it.
// - A host I/O read of the status address returns all eight status bits.
module hcs_status (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_rst,
   input  wire logic                       i_clk_en,
   input  wire hcs_pkg::hcs_host_ev_type   i_host_ev,
   input  wire hcs_pkg::hcs_local_ev_type  i_local_ev,
   input  wire hcs_pkg::hcs_fast_gate_type i_fast_gate,
   output logic [7:0]                      o_status,
   output logic [7:0]                      o_host_rd_data,
   output logic                            o_host_rd_valid,
   output logic                            o_input_full_irq
);
   import hcs_pkg::*;

   // ***********************************************
   // storage
   // ***********************************************
   logic [7:0] user_reg;
   logic       cmd_reg;
   logic       in_full;
   logic       out_full;
   logic       in_set;
   logic       in_clear;
   logic       out_set;
   logic       out_clear;
   logic [7:0] status_now;
   logic [7:0] host_rd_data_reg;
   logic       host_rd_valid_reg;

   // ***********************************************
   // user bits
   // ***********************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         user_reg <= HCS_STATUS_RESET;
      end else if (i_clk_en && i_local_ev.wr_status) begin
         user_reg <= i_local_ev.wr_data & HCS_USER_MASK;
      end
   end

   // ***********************************************
   // command flag
   // ***********************************************
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cmd_reg <= HCS_CMD_IS_DATA;
      end else if (i_clk_en && i_host_ev.wr_input) begin
         cmd_reg <= i_host_ev.addr_bit2;
      end
   end

   // ***********************************************
   // input-full flag
   // ***********************************************
   // fast gate terms replace the normal ones wholesale; their source owns the decode
   always_comb begin
      if (i_fast_gate.on) begin
         in_set   = i_fast_gate.set;
         in_clear = i_fast_gate.clear;
      end else begin
         in_set   = i_host_ev.wr_input;
         in_clear = i_local_ev.rd_input;
      end
   end

   hcs_flag_cell u_in_full (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_clk_en   (i_clk_en),
      .i_set      (in_set),
      .i_clear    (in_clear),
      .o_flag     (in_full)
   );

   // ***********************************************
   // output-full flag
   // ***********************************************
   assign out_set   = i_local_ev.wr_output;
   // writing 1 is no clear term, so the flag simply holds
   assign out_clear = i_host_ev.rd_output
                    | (i_local_ev.wr_status && !i_local_ev.wr_data[HCS_BIT_OUT_FULL]);

   hcs_flag_cell u_out_full (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_clk_en   (i_clk_en),
      .i_set      (out_set),
      .i_clear    (out_clear),
      .o_flag     (out_full)
   );

   // ***********************************************
   // status assembly and host read
   // ***********************************************
   always_comb begin
      status_now                   = user_reg;
      status_now[HCS_BIT_CMD]      = cmd_reg;
      status_now[HCS_BIT_IN_FULL]  = in_full;
      status_now[HCS_BIT_OUT_FULL] = out_full;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         host_rd_data_reg <= HCS_STATUS_RESET;
      end else if (i_clk_en && i_host_ev.rd_status) begin
         host_rd_data_reg <= status_now;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         host_rd_valid_reg <= 1'b0;
      end else if (i_clk_en) begin
         host_rd_valid_reg <= i_host_ev.rd_status;
      end
   end

   assign o_status         = status_now;
   assign o_host_rd_data   = host_rd_data_reg;
   assign o_host_rd_valid  = host_rd_valid_reg;
   assign o_input_full_irq = in_full;

   // ***********************************************
   // checks
   // ***********************************************
   user_bits_write_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_local_ev.wr_status)
      |=> ((o_status & HCS_USER_MASK) == ($past(i_local_ev.wr_data) & HCS_USER_MASK)))
      else $error("user bits not taken from local write");

   user_bits_hold_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      !(i_clk_en && i_local_ev.wr_status)
      |=> ((o_status & HCS_USER_MASK) == ($past(o_status) & HCS_USER_MASK)))
      else $error("user bits changed without local write");

   cmd_flag_copy_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_host_ev.wr_input)
      |=> (o_status[HCS_BIT_CMD] == $past(i_host_ev.addr_bit2)))
      else $error("command flag not copied from address bit 2");

   irq_follows_flag_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      $rose(o_input_full_irq)
      |-> $past(i_clk_en && (i_fast_gate.on ? i_fast_gate.set : i_host_ev.wr_input)))
      else $error("interrupt request rose without a set term");

   in_full_set_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && !i_fast_gate.on && i_host_ev.wr_input)
      |=> o_status[HCS_BIT_IN_FULL])
      else $error("input-full not set by host write");

   in_full_clear_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && !i_fast_gate.on && i_local_ev.rd_input && !i_host_ev.wr_input)
      |=> !o_status[HCS_BIT_IN_FULL])
      else $error("input-full not cleared by local read");

   fast_gate_set_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_fast_gate.on && i_fast_gate.set)
      |=> o_status[HCS_BIT_IN_FULL])
      else $error("input-full not set by fast gate term");

   fast_gate_clear_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_fast_gate.on && i_fast_gate.clear && !i_fast_gate.set)
      |=> !o_status[HCS_BIT_IN_FULL])
      else $error("input-full not cleared by fast gate term");

   fast_gate_hold_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_fast_gate.on && !i_fast_gate.set && !i_fast_gate.clear)
      |=> $stable(o_status[HCS_BIT_IN_FULL]))
      else $error("input-full moved under fast gate without its terms");

   out_full_set_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_local_ev.wr_output) |=> o_status[HCS_BIT_OUT_FULL])
      else $error("output-full not set by local write");

   out_full_host_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_host_ev.rd_output && !i_local_ev.wr_output)
      |=> !o_status[HCS_BIT_OUT_FULL])
      else $error("output-full not cleared by host read");

   out_full_zero_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_local_ev.wr_status && !i_local_ev.wr_data[HCS_BIT_OUT_FULL]
       && !i_local_ev.wr_output)
      |=> !o_status[HCS_BIT_OUT_FULL])
      else $error("output-full not cleared by writing 0");

   out_full_source_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      $rose(o_status[HCS_BIT_OUT_FULL]) |-> $past(i_local_ev.wr_output && i_clk_en))
      else $error("output-full rose without output data write");

   status_reset_a : assert property (
      @(posedge i_core_clk)
      i_rst |=> (o_status == HCS_STATUS_RESET && !o_host_rd_valid
                 && o_host_rd_data == HCS_STATUS_RESET))
      else $error("status not zero in reset");

   host_read_a : assert property (
      @(posedge i_core_clk) disable iff (i_rst)
      (i_clk_en && i_host_ev.rd_status)
      |=> (o_host_rd_valid && o_host_rd_data == $past(o_status)))
      else $error("host status read wrong or missing");

endmodule : hcs_status

// *** verif/hcs_host_model.sv ***
`timescale 1ns/10ps
// ***********************************************
// host side: io cycles seen as one-cycle strobes
// ***********************************************
module hcs_host_model (
   output hcs_pkg::hcs_host_ev_type o_host_ev
);
   import hcs_pkg::*;

   initial o_host_ev = '0;

   // called just after an edge, held for exactly one cycle by the caller
   task automatic io_cycle(input logic [3:0] ev);
      o_host_ev = ev;
   endtask : io_cycle

endmodule : hcs_host_model

// *** verif/host_if_status_channel_one_tb_top.sv ***
`timescale 1ns/10ps
module host_if_status_channel_one_tb_top;
   import hcs_pkg::*;

   // ***********************************************
   // stimulus and observation
   // ***********************************************
   logic              i_core_clk  = 1'b0;
   logic              i_rst       = 1'b1;
   logic              i_clk_en    = 1'b0;
   hcs_host_ev_type   host_ev;
   hcs_local_ev_type  i_local_ev  = '0;
   hcs_fast_gate_type i_fast_gate = '0;
   logic [7:0]        o_status;
   logic [7:0]        o_host_rd_data;
   logic              o_host_rd_valid;
   logic              o_input_full_irq;
   logic [7:0]        exp_status  = 8'h00;
   logic [7:0]        note_q[$];
   logic [31:0]       seed        = 32'h1F67;
   int                miscompares = 0;
   int                checked     = 0;

   always #4 i_core_clk = ~i_core_clk;

   hcs_host_model u_host (.o_host_ev(host_ev));

   hcs_status u_dut (
      .i_core_clk      (i_core_clk),
      .i_rst           (i_rst),
      .i_clk_en        (i_clk_en),
      .i_host_ev       (host_ev),
      .i_local_ev      (i_local_ev),
      .i_fast_gate     (i_fast_gate),
      .o_status        (o_status),
      .o_host_rd_data  (o_host_rd_data),
      .o_host_rd_valid (o_host_rd_valid),
      .o_input_full_irq(o_input_full_irq)
   );

   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [7:0] seen, input logic [7:0] expct);
      checked++;
      if (seen !== expct) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expct);
      end
   endtask : check

   task automatic wrap_up();
      check(8'(note_q.size()), 8'h00);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : wrap_up

   // one cycle of traffic; expectation advances with the taking edge
   task automatic step(input logic en, input logic [3:0] h, input logic [10:0] l,
                       input logic [2:0] g);
      hcs_host_ev_type   hv;
      hcs_local_ev_type  lv;
      hcs_fast_gate_type gv;
      logic [7:0]        nx;
      hv = h;
      lv = l;
      gv = g;
      nx = exp_status;
      @(posedge i_core_clk);
      #1;
      check(o_status, exp_status);
      check({7'h00, o_input_full_irq}, {7'h00, exp_status[1]});
      i_clk_en = en;
      u_host.io_cycle(h);
      i_local_ev = lv;
      i_fast_gate = gv;
      if (en) begin
         if (hv.rd_status) note_q.push_back(exp_status);
         if (lv.wr_status) nx = (nx & ~HCS_USER_MASK) | (lv.wr_data & HCS_USER_MASK);
         if (lv.wr_status && !lv.wr_data[0]) nx[0] = 1'b0;
         if (hv.rd_output) nx[0] = 1'b0;
         if (lv.wr_output) nx[0] = 1'b1;
         if (hv.wr_input) nx[3] = hv.addr_bit2;
         if (gv.on) begin
            if (gv.clear) nx[1] = 1'b0;
            if (gv.set) nx[1] = 1'b1;
         end else begin
            if (lv.rd_input) nx[1] = 1'b0;
            if (hv.wr_input) nx[1] = 1'b1;
         end
      end
      exp_status = nx;
   endtask : step

   // ***********************************************
   // result watcher: a stalled valid counts once
   // ***********************************************
   // mid-cycle look keeps clear of the edge that launches valid
   always @(negedge i_core_clk) begin
      if (o_host_rd_valid === 1'b1 && i_clk_en === 1'b1) begin
         if (note_q.size() == 0) check(o_host_rd_data, 8'hXX);
         else check(o_host_rd_data, note_q.pop_front());
      end
   end

   initial begin
      #(8 * 3000);
      miscompares++;
      wrap_up();
   end

   // ***********************************************
   // main sequence
   // ***********************************************
   initial begin
      repeat (6) @(posedge i_core_clk);
      #1 i_rst = 1'b0;
      step(1'b1, 4'h1, 11'h000, 3'h0); // reset value read by the host
      step(1'b1, 4'hC, 11'h001, 3'h0); // command write, output data write
      step(1'b1, 4'h1, 11'h5FC, 3'h0); // user bits, bit0 write of 1
      for (int i = 0; i < 2000; i++) begin
         seed = lfsr(seed);
         if (i == 1000) begin
            @(posedge i_core_clk);
            #1;
            i_rst = 1'b1;
            // quiet inputs, or stale events are taken again after release
            i_clk_en = 1'b0;
            i_local_ev = '0;
            i_fast_gate = '0;
            u_host.io_cycle(4'h0);
            exp_status = 8'h00;
            note_q.delete();
            @(posedge i_core_clk);
            #1;
            check(o_status, 8'h00);
            check(o_host_rd_data, 8'h00);
            check({7'h00, o_host_rd_valid}, 8'h00);
            check({7'h00, o_input_full_irq}, 8'h00);
            i_rst = 1'b0;
         end
         step(|seed[21:19], seed[3:0], seed[14:4], {seed[15] & seed[16], seed[18:17]});
      end
      repeat (3) step(1'b1, 4'h0, 11'h000, 3'h0);
      wrap_up();
   end

endmodule : host_if_status_channel_one_tb_top
